/* dpc_defs.vh */
// constants for the dual potentiometer command unit
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH
`define DPC_WORD_BITS   24
`define DPC_OP_MSB      23
`define DPC_OP_LSB      20
`define DPC_SLOT_MSB    19
`define DPC_SLOT_LSB    18
`define DPC_CHAN_MSB    17
`define DPC_CHAN_LSB    16
`define DPC_BUF_BIT     8
`define DPC_OP_NOP      4'h0
`define DPC_OP_WAKE     4'h1
`define DPC_OP_PROG     4'h2
`define DPC_OP_SAVE     4'h3
`define DPC_OP_WRTAP    4'h4
`define DPC_OP_UP       4'h7
`define DPC_OP_SLEEP    4'h8
`define DPC_OP_SWRST    4'h9
`define DPC_OP_RDSLOT   4'hA
`define DPC_OP_RECALL   4'hB
`define DPC_OP_RDTAP    4'hC
`define DPC_OP_ERASE    4'hD
`define DPC_OP_DOWN     4'hF
`define DPC_SLOT_RESET  9'h000
`define DPC_BUSY_CYCLES 4
`endif

/* dpc_slot_mem.v */
// stored setting slots: 8 words of 9 bits with registered read port
`default_nettype none
`include "dpc_defs.vh"
module dpc_slot_mem #(
  parameter AW = 3,
  parameter DW = 9
) (
  input  wire          mclk,
  input  wire          writeEn,
  input  wire [AW-1:0] writeAddr,
  input  wire [DW-1:0] writeData,
  input  wire [AW-1:0] readAddr,
  output reg  [DW-1:0] readData
);
  reg [DW-1:0] mem [0:(1<<AW)-1];
  integer i;
  // blank slots at start of simulation; a real array holds its contents across power
  initial
  begin
    for (i = 0; i < (1<<AW); i = i + 1)
      mem[i] = `DPC_SLOT_RESET;
  end
  always @(posedge mclk)
  begin
    if (writeEn)
      mem[writeAddr] <= writeData;
    readData <= mem[readAddr];
  end
endmodule // dpc_slot_mem
`default_nettype wire

/* dpc_command_unit.v */
// serial command unit for a dual 256-tap non-volatile potentiometer
`default_nettype none
`include "dpc_defs.vh"
module dpc_command_unit #(
  parameter TAP_BITS = 8,
  parameter CHANNELS = 2
) (
  input  wire                          mclk,
  input  wire                          reset,
  input  wire                          sclkPin,
  input  wire                          selectNPin,
  input  wire                          sdiPin,
  input  wire                          writeProtectNPin,
  output wire                          sdoOut,
  output wire                          sdoOe,
  output wire                          readyOut,
  output wire                          readyOe,
  output wire [CHANNELS*TAP_BITS-1:0]  wiperTapValue,
  output wire [CHANNELS-1:0]           bufferSelectBit,
  output wire                          asleep
);
  localparam ST_BOOT0 = 5'h01;
  localparam ST_BOOT1 = 5'h02;
  localparam ST_IDLE  = 5'h04;
  localparam ST_EXEC  = 5'h08;
  localparam ST_BUSY  = 5'h10;
  localparam [TAP_BITS-1:0] TAP_MAX = {TAP_BITS{1'b1}};

  reg [1:0] sclkSync_reg, selSync_reg, sdiSync_reg, wpSync_reg;
  reg       sclkLast_reg, selLast_reg;
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sclkSync_reg <= 2'h0;
      selSync_reg  <= 2'h3;
      sdiSync_reg  <= 2'h0;
      wpSync_reg   <= 2'h3;
      sclkLast_reg <= 1'b0;
      selLast_reg  <= 1'b1;
    end
    else
    begin
      sclkSync_reg <= {sclkSync_reg[0], sclkPin};
      selSync_reg  <= {selSync_reg[0], selectNPin};
      sdiSync_reg  <= {sdiSync_reg[0], sdiPin};
      wpSync_reg   <= {wpSync_reg[0], writeProtectNPin};
      sclkLast_reg <= sclkSync_reg[1];
      selLast_reg  <= selSync_reg[1];
    end
  end
  wire sclkS   = sclkSync_reg[1];
  wire selS    = selSync_reg[1];
  wire sclkRise = sclkS & ~sclkLast_reg;
  wire sclkFall = ~sclkS & sclkLast_reg;
  wire selFall  = ~selS & selLast_reg;
  wire selRise  = selS & ~selLast_reg;
  wire active   = ~selS;
  wire protect  = ~wpSync_reg[1];

  reg [23:0] shift_reg;
  reg [23:0] outShift_reg;
  reg [4:0]  bitCount_reg;
  reg        sdo_reg;
  reg [23:0] word_reg;
  reg        wordValid_reg;
  reg [23:0] readWord_reg;
  reg [4:0]  state_reg;
  reg        sleep_reg;
  reg        ready_reg;
  reg [2:0]  busyCount_reg;
  reg        bootChan_reg;
  reg [TAP_BITS-1:0] tap_reg [0:CHANNELS-1];
  reg [CHANNELS-1:0] buf_reg;

  wire [3:0] opcode = word_reg[`DPC_OP_MSB:`DPC_OP_LSB];
  wire [1:0] slotSel = word_reg[`DPC_SLOT_MSB:`DPC_SLOT_LSB];
  wire [1:0] chanSel = word_reg[`DPC_CHAN_MSB:`DPC_CHAN_LSB];
  wire       chanOk  = (chanSel < CHANNELS);
  wire       chIdx   = chanSel[0];
  wire [TAP_BITS-1:0] curTap = tap_reg[chIdx];

  reg        memWe;
  reg [2:0]  memWa;
  reg [8:0]  memWd;
  reg [2:0]  memRa;
  wire [8:0] memRd;
  dpc_slot_mem #(.AW(3), .DW(9)) slotMem (
    .mclk      (mclk),
    .writeEn   (memWe),
    .writeAddr (memWa),
    .writeData (memWd),
    .readAddr  (memRa),
    .readData  (memRd)
  );

  // shift path: input on rising edge, output on falling edge
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      shift_reg     <= 24'h000000;
      outShift_reg  <= 24'h000000;
      bitCount_reg  <= 5'h00;
      sdo_reg       <= 1'b0;
      word_reg      <= 24'h000000;
      wordValid_reg <= 1'b0;
    end
    else
    begin
      if (selFall)
      begin
        bitCount_reg <= 5'h00;
        sdo_reg      <= outShift_reg[23];
      end
      else if (active && sclkRise)
      begin
        shift_reg    <= {shift_reg[22:0], sdiSync_reg[1]};
        outShift_reg <= {outShift_reg[22:0], sdiSync_reg[1]};
        if (bitCount_reg == `DPC_WORD_BITS - 1)
          bitCount_reg <= 5'h00;
        else
          bitCount_reg <= bitCount_reg + 5'h01;
      end
      else if (active && sclkFall)
        sdo_reg <= outShift_reg[23];
      if (selRise)
      begin
        word_reg      <= shift_reg;
        wordValid_reg <= (bitCount_reg == 5'h00);
        outShift_reg  <= shift_reg;
      end
      else if (state_reg == ST_EXEC && wordValid_reg && !sleep_reg &&
               (opcode == `DPC_OP_RDTAP || opcode == `DPC_OP_RDSLOT))
        outShift_reg <= readWord_reg;
    end
  end
  assign sdoOut = sdo_reg;
  // open drain: enable low drive only while selected and bit is zero
  assign sdoOe  = active & ~sdo_reg;

  // read data formed combinationally in the same cycle execution uses it
  always @*
  begin
    readWord_reg = word_reg;
    readWord_reg[8:0] = 9'h000;
    if (opcode == `DPC_OP_RDTAP)
      readWord_reg[8:0] = {buf_reg[chIdx], curTap};
    else
      readWord_reg[8:0] = memRd;
  end

  always @*
  begin
    memWe = 1'b0;
    memWa = {slotSel, chIdx};
    memWd = 9'h000;
    memRa = {slotSel, chIdx};
    if (state_reg == ST_BOOT0 || state_reg == ST_BOOT1)
      memRa = {2'b00, bootChan_reg};
    // address the incoming word at select rise so read and recall see fresh data
    if (state_reg == ST_IDLE && selRise)
      memRa = {shift_reg[`DPC_SLOT_MSB:`DPC_SLOT_LSB], shift_reg[`DPC_CHAN_LSB]};
    if (state_reg == ST_EXEC && !sleep_reg && !protect && chanOk)
    begin
      if (opcode == `DPC_OP_PROG)
      begin
        memWe = 1'b1;
        memWd = {word_reg[`DPC_BUF_BIT], word_reg[7:0]};
      end
      else if (opcode == `DPC_OP_SAVE)
      begin
        memWe = 1'b1;
        memWd = {buf_reg[chIdx], curTap};
      end
      else if (opcode == `DPC_OP_ERASE)
      begin
        memWe = 1'b1;
        memWd = `DPC_SLOT_RESET;
      end
    end
  end

  wire needsBusy = (opcode == `DPC_OP_RDTAP) || (opcode == `DPC_OP_RDSLOT) ||
                   (opcode == `DPC_OP_PROG) || (opcode == `DPC_OP_RECALL) ||
                   (opcode == `DPC_OP_SAVE);

  // control sequencer
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      state_reg     <= ST_BOOT0;
      sleep_reg     <= 1'b1;
      ready_reg     <= 1'b0;
      busyCount_reg <= 3'h0;
      bootChan_reg  <= 1'b0;
      tap_reg[0]    <= {TAP_BITS{1'b0}};
      tap_reg[1]    <= {TAP_BITS{1'b0}};
      buf_reg       <= {CHANNELS{1'b0}};
    end
    else
    begin
      if (selFall)
        ready_reg <= 1'b1;
      case (state_reg)
        ST_BOOT0:
          state_reg <= ST_BOOT1;
        ST_BOOT1:
        begin
          tap_reg[bootChan_reg] <= memRd[7:0];
          buf_reg[bootChan_reg] <= memRd[8];
          bootChan_reg <= ~bootChan_reg;
          if (bootChan_reg)
          begin
            state_reg <= ST_IDLE;
            ready_reg <= 1'b1;
          end
          else
            state_reg <= ST_BOOT0;
        end
        ST_IDLE:
          if (selRise)
            state_reg <= ST_EXEC;
        ST_EXEC:
        begin
          state_reg <= ST_IDLE;
          // an incomplete word runs nothing; all-zero opcode likewise
          if (wordValid_reg && (!sleep_reg || opcode == `DPC_OP_WAKE))
          begin
            if (needsBusy)
            begin
              ready_reg     <= 1'b0;
              busyCount_reg <= 3'h0;
              state_reg     <= ST_BUSY;
            end
            case (opcode)
              `DPC_OP_WAKE:
                sleep_reg <= 1'b0;
              `DPC_OP_SLEEP:
                sleep_reg <= 1'b1;
              `DPC_OP_SWRST:
              begin
                sleep_reg    <= 1'b1;
                ready_reg    <= 1'b0;
                bootChan_reg <= 1'b0;
                state_reg    <= ST_BOOT0;
              end
              `DPC_OP_WRTAP:
                if (!protect && chanOk)
                  tap_reg[chIdx] <= word_reg[7:0];
              `DPC_OP_UP:
                if (!protect && chanOk && curTap != TAP_MAX)
                  tap_reg[chIdx] <= curTap + 1'b1;
              `DPC_OP_DOWN:
                if (!protect && chanOk && curTap != {TAP_BITS{1'b0}})
                  tap_reg[chIdx] <= curTap - 1'b1;
              `DPC_OP_RECALL:
                if (chanOk)
                begin
                  tap_reg[chIdx] <= memRd[7:0];
                  buf_reg[chIdx] <= memRd[8];
                end
              default:
                sleep_reg <= sleep_reg;
            endcase
          end
        end
        ST_BUSY:
        begin
          // memory access cycle modelled as a short fixed delay
          busyCount_reg <= busyCount_reg + 3'h1;
          if (busyCount_reg == `DPC_BUSY_CYCLES - 1)
          begin
            ready_reg <= 1'b1;
            state_reg <= ST_IDLE;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // open drain, active-low busy: pull low while not ready
  assign readyOut = ready_reg;
  assign readyOe  = ~ready_reg;
  assign wiperTapValue   = {tap_reg[1], tap_reg[0]};
  assign bufferSelectBit = buf_reg;
  assign asleep = sleep_reg;
endmodule // dpc_command_unit
`default_nettype wire

/* dpc_cmd_props.sv */
// port checker for the potentiometer command unit
`default_nettype none
module dpc_cmd_props #(
  parameter TAP_BITS = 8,
  parameter CHANNELS = 2
) (
  input wire logic                         mclk,
  input wire logic                         reset,
  input wire logic                         selectNPin,
  input wire logic                         sdoOut,
  input wire logic                         sdoOe,
  input wire logic                         readyOut,
  input wire logic                         readyOe,
  input wire logic [CHANNELS*TAP_BITS-1:0] wiperTapValue,
  input wire logic [CHANNELS-1:0]          bufferSelectBit,
  input wire logic                         asleep
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_ready_at_select: assert property ($fell(selectNPin) |-> ##[1:5] readyOut)
    else $error("ready not raised after select fall");
  a_ready_pin_pair: assert property (readyOe == !readyOut)
    else $error("ready pin enable disagrees with ready level");
  a_busy_window: assert property ($fell(readyOut) |-> !readyOut[*3] ##[1:4] readyOut)
    else $error("busy period of wrong length");
  a_busy_when_idle: assert property ($fell(readyOut) |-> selectNPin)
    else $error("busy began inside a frame");
  a_sdo_released: assert property (selectNPin[*4] |-> !sdoOe)
    else $error("serial output driven while deselected");
  a_sdo_drive_low: assert property (sdoOe |-> !sdoOut)
    else $error("serial output enabled while high");
  a_boot_asleep: assert property ($past(reset) |-> asleep && !readyOut)
    else $error("not asleep and busy after reset");
  a_tap_quiet: assert property (!selectNPin[*8] |-> $stable(wiperTapValue))
    else $error("tap changed inside a frame");
  a_buf_quiet: assert property (!selectNPin[*8] |-> $stable(bufferSelectBit))
    else $error("buffer select changed inside a frame");
  c_busy: cover property ($fell(readyOut));
  c_wake: cover property ($fell(asleep));
  c_buf_on: cover property ($rose(bufferSelectBit[1]));
endmodule // dpc_cmd_props
bind dpc_command_unit dpc_cmd_props #(.TAP_BITS(TAP_BITS), .CHANNELS(CHANNELS))
  dpc_cmd_props_inst (.mclk(mclk), .reset(reset), .selectNPin(selectNPin), .sdoOut(sdoOut),
  .sdoOe(sdoOe), .readyOut(readyOut), .readyOe(readyOe), .wiperTapValue(wiperTapValue),
  .bufferSelectBit(bufferSelectBit), .asleep(asleep));
`default_nettype wire

/* dpc_host_model.sv */
// host model framing words on the serial link
`default_nettype none
module dpc_host_model (
  input  wire logic mclk,
  input  wire logic sdoOe,
  input  wire logic readyOe,
  output var  logic sclkPin,
  output var  logic selectNPin,
  output var  logic sdiPin
);
  timeunit 1ns;
  timeprecision 1ns;
  // both pins are open drain with pull-ups
  wire logic sdoLine = sdoOe ? 1'h0 : 1'h1;
  wire logic readyLine = readyOe ? 1'h0 : 1'h1;
  initial
  begin
    sclkPin = 1'h0;
    selectNPin = 1'h1;
    sdiPin = 1'h0;
  end
  // sclk rests low between frames; data moves only with sclk low
  task automatic xfer(input logic [47:0] w, input int n, output logic [47:0] got);
    got = '0;
    @(negedge mclk);
    selectNPin = 1'h0;
    #400;
    for (int i = n - 1; i >= 0; i--)
    begin
      sdiPin = w[i];
      #200 sclkPin = 1'h1;
      got = {got[46:0], sdoLine};
      #200 sclkPin = 1'h0;
    end
    sdiPin = ~sdiPin;
    #200 selectNPin = 1'h1;
    #800;
    // a stuck busy line is caught by the bench's cycle ceiling
    while (!readyLine)
      #50;
  endtask
endmodule // dpc_host_model
`default_nettype wire

/* dpc_command_unit_tb_top.sv */
// self-checking bench for the potentiometer command unit
`default_nettype none
`include "dpc_defs.vh"
module dpc_command_unit_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk = 1'h0;
  logic        reset = 1'h1;
  logic        writeProtectNPin = 1'h1;
  wire logic   sclkPin, selectNPin, sdiPin, sdoOut, sdoOe, readyOut, readyOe, asleep;
  wire logic [15:0] wiperTapValue;
  wire logic [1:0]  bufferSelectBit;
  logic [47:0] got;
  int          n_errors = 0;
  int          n_tests = 0;
  int          cycles = 0;
  always #25 mclk = ~mclk;
  dpc_command_unit dpc_command_unit_inst (.mclk(mclk), .reset(reset), .sclkPin(sclkPin),
    .selectNPin(selectNPin), .sdiPin(sdiPin), .writeProtectNPin(writeProtectNPin),
    .sdoOut(sdoOut), .sdoOe(sdoOe), .readyOut(readyOut), .readyOe(readyOe),
    .wiperTapValue(wiperTapValue), .bufferSelectBit(bufferSelectBit), .asleep(asleep));
  dpc_host_model dpc_host_model_inst (.mclk(mclk), .sdoOe(sdoOe), .readyOe(readyOe),
    .sclkPin(sclkPin), .selectNPin(selectNPin), .sdiPin(sdiPin));
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles > 20000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] cmd(input logic [3:0] op, input logic [1:0] sl, ch,
    input logic [7:0] d1, d2);
    return {op, sl, ch, d1, d2};
  endfunction
  task automatic send(input logic [23:0] w);
    dpc_host_model_inst.xfer({24'h0, w}, 24, got);
  endtask
  // the read result only appears while the following word goes in
  task automatic readback(input logic [23:0] w, input logic [8:0] exp);
    send(w);
    send(24'h0);
    check(got[23:0], {w[23:9], exp});
  endtask
  task automatic t_sleep();
    check(asleep, 24'h1);
    send(cmd(`DPC_OP_WRTAP, 2'h0, 2'h0, 8'h0, 8'h5A));
    check(wiperTapValue, 24'h0);
    send(cmd(`DPC_OP_WAKE, 2'h0, 2'h0, 8'h0, 8'h0));
    check(asleep, 24'h0);
  endtask
  task automatic t_write_step();
    send(cmd(`DPC_OP_WRTAP, 2'h0, 2'h0, 8'h01, 8'hFE));
    check(wiperTapValue, 24'h00FE);
    check(bufferSelectBit, 24'h0);
    send(cmd(`DPC_OP_UP, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_UP, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_WRTAP, 2'h0, 2'h1, 8'h0, 8'h01));
    send(cmd(`DPC_OP_DOWN, 2'h0, 2'h1, 8'h0, 8'h0));
    send(cmd(`DPC_OP_DOWN, 2'h0, 2'h1, 8'h0, 8'h0));
    check(wiperTapValue, 24'h00FF);
    send(cmd(`DPC_OP_WRTAP, 2'h0, 2'h2, 8'h0, 8'h77));
    check(wiperTapValue, 24'h00FF);
  endtask
  task automatic t_slots();
    send(cmd(`DPC_OP_ERASE, 2'h2, 2'h1, 8'h0, 8'h0));
    send(cmd(`DPC_OP_PROG, 2'h2, 2'h1, 8'h01, 8'hA5));
    readback(cmd(`DPC_OP_RDSLOT, 2'h2, 2'h1, 8'h0, 8'h0), 9'h1A5);
    send(cmd(`DPC_OP_RECALL, 2'h2, 2'h1, 8'h0, 8'h0));
    check(wiperTapValue, 24'hA5FF);
    check(bufferSelectBit, 24'h2);
    readback(cmd(`DPC_OP_RDTAP, 2'h0, 2'h1, 8'h0, 8'h0), 9'h1A5);
    send(cmd(`DPC_OP_ERASE, 2'h3, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_SAVE, 2'h3, 2'h0, 8'h0, 8'h0));
    readback(cmd(`DPC_OP_RDSLOT, 2'h3, 2'h0, 8'h0, 8'h0), 9'h0FF);
    send(cmd(`DPC_OP_ERASE, 2'h3, 2'h0, 8'h0, 8'h0));
    readback(cmd(`DPC_OP_RDSLOT, 2'h3, 2'h0, 8'h0, 8'h0), 9'h000);
  endtask
  task automatic t_frames();
    dpc_host_model_inst.xfer({24'h0, cmd(`DPC_OP_WRTAP, 2'h0, 2'h0, 8'h0, 8'h11)}, 23, got);
    check(wiperTapValue, 24'hA5FF);
    dpc_host_model_inst.xfer({cmd(`DPC_OP_WRTAP, 2'h0, 2'h1, 8'h0, 8'h22),
      cmd(`DPC_OP_WRTAP, 2'h0, 2'h0, 8'h0, 8'h33)}, 48, got);
    check(wiperTapValue, 24'hA533);
    check(got[23:0], cmd(`DPC_OP_WRTAP, 2'h0, 2'h1, 8'h0, 8'h22));
    send(24'h0);
    check({asleep, bufferSelectBit, wiperTapValue}, 24'h2A533);
  endtask
  task automatic t_protect();
    @(negedge mclk) writeProtectNPin = 1'h0;
    send(cmd(`DPC_OP_WRTAP, 2'h0, 2'h0, 8'h0, 8'h44));
    send(cmd(`DPC_OP_DOWN, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_ERASE, 2'h2, 2'h1, 8'h0, 8'h0));
    check(wiperTapValue, 24'hA533);
    readback(cmd(`DPC_OP_RDSLOT, 2'h2, 2'h1, 8'h0, 8'h0), 9'h1A5);
    send(cmd(`DPC_OP_RECALL, 2'h3, 2'h0, 8'h0, 8'h0));
    check(wiperTapValue, 24'hA500);
    @(negedge mclk) writeProtectNPin = 1'h1;
  endtask
  task automatic t_power();
    send(cmd(`DPC_OP_ERASE, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_PROG, 2'h0, 2'h0, 8'h01, 8'h3C));
    send(cmd(`DPC_OP_SWRST, 2'h0, 2'h0, 8'h0, 8'h0));
    check({asleep, bufferSelectBit, wiperTapValue}, 24'h05003C);
    send(cmd(`DPC_OP_WAKE, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_SLEEP, 2'h0, 2'h0, 8'h0, 8'h0));
    send(cmd(`DPC_OP_UP, 2'h0, 2'h0, 8'h0, 8'h0));
    check({asleep, wiperTapValue}, 24'h1003C);
    @(negedge mclk) reset = 1'h1;
    repeat (2) @(negedge mclk);
    reset = 1'h0;
    repeat (12) @(negedge mclk);
    check({asleep, bufferSelectBit, wiperTapValue}, 24'h05003C);
  endtask
  initial
  begin
    repeat (12) @(negedge mclk);
    reset = 1'h0;
    repeat (10) @(negedge mclk);
    t_sleep();
    t_write_step();
    t_slots();
    t_frames();
    t_protect();
    t_power();
    tally_and_finish();
  end
endmodule // dpc_command_unit_tb_top
`default_nettype wire
